// File: common/fcs_pkg.sv
// shared constants and types for the flash command sequencer
package fcs_pkg;
    // ------------------------------------------------------------
    // command decoding
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam logic [6:0] CMD_ADDR_A = 7'h55;
    localparam logic [6:0] CMD_ADDR_B = 7'h2a;
    localparam int CMD_LSB = 9;
    localparam logic [7:0] D_AA = 8'haa;
    localparam logic [7:0] D_55 = 8'h55;
    localparam logic [7:0] D_READ = 8'hf0;
    localparam logic [7:0] D_IDREAD = 8'h90;
    localparam logic [7:0] D_PROG = 8'ha0;
    localparam logic [7:0] D_ERASE = 8'h80;
    localparam logic [7:0] D_CHIP = 8'h10;
    localparam logic [7:0] D_BLOCK = 8'h30;
    localparam logic [31:0] NO_WRITE = 32'hffffffff;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int NBLK = 4;
    localparam int BLK_W = 2;
    localparam int PAGE_WORDS = 16;
    localparam int PAGE_W = 4;
    localparam int WORD_W = 8;
    localparam int NWORDS = 256;
    localparam int BLK_LSB = 8;
    localparam logic [3:0] PROT_RST = 4'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int RST_MIN_NS = 500;
    localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_WAIT_US = 200;
    localparam int READ_WAIT_CYC = READ_WAIT_US * CLK_MHZ;
    localparam int OP_CYC = 16;
    localparam int CNT_W = 16;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_READ = 7'h01, S_SEQ = 7'h02, S_PROG = 7'h04, S_BUSY = 7'h08,
        S_IDRD = 7'h10, S_FAIL = 7'h20, S_LOAD = 7'h40
    } fcs_state_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_PROG = 3'h1, OP_CHIP = 3'h2, OP_BLOCK = 3'h3
    } fcs_op_t;
endpackage : fcs_pkg

// File: common/fcs_bus_if.sv
// store-cycle link between the cpu side and the flash sequencer
`timescale 1ns/1ps
interface fcs_bus_if;
    import fcs_pkg::*;
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic ready_busy_flag;
    logic rd_refused;
    modport dev (input wr, rd, addr, wdata, output rdata, rvalid, ready_busy_flag, rd_refused);
    modport host (output wr, rd, addr, wdata, input rdata, rvalid, ready_busy_flag, rd_refused);
endinterface : fcs_bus_if

// File: src/fcs_device.sv
// flash command sequencer: device end with a small model array
`timescale 1ns/1ps
module fcs_device
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // cpu link
    fcs_bus_if.dev bus,
    // protection and status
    input wire logic [NBLK-1:0] prot,
    input wire logic op_fail,
    output logic read_mode
);
    typedef struct packed {
        fcs_state_t st;
        fcs_op_t op;
        logic [2:0] step;
        logic [PAGE_W-1:0] widx;
        logic [WORD_W-1:0] pbase;
        logic [BLK_W-1:0] blk;
        logic [CNT_W-1:0] cnt;
        logic rdy;
        logic refused;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic rmode;
    } fcs_dev_state_t;

    fcs_dev_state_t s_reg, s_next;
    logic [DATA_W-1:0] mem [NWORDS];
    logic [DATA_W-1:0] pagebuf [PAGE_WORDS];
    logic [6:0] cmd_a;
    logic [7:0] d8;
    logic is_a, is_b;
    logic pb_we;
    logic [WORD_W-1:0] waddr;

    assign cmd_a = bus.addr[CMD_LSB +: 7];
    assign d8 = bus.wdata[7:0];
    assign is_a = cmd_a == CMD_ADDR_A;
    assign is_b = cmd_a == CMD_ADDR_B;
    assign waddr = bus.addr[WORD_W+1:2];
    assign bus.rdata = s_reg.rdata;
    assign bus.rvalid = s_reg.rvalid;
    assign bus.ready_busy_flag = s_reg.rdy;
    assign bus.rd_refused = s_reg.refused;
    assign read_mode = s_reg.rmode;

    // ------------------------------------------------------------
    // sequence recognition
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.refused = 1'b0;
        pb_we = 1'b0;
        unique case (s_reg.st)
            S_READ, S_IDRD: begin
                if (bus.rd) begin
                    s_next.rvalid = 1'b1;
                    s_next.rdata = (s_reg.st == S_IDRD) ? '0 : mem[waddr];
                end
                if (bus.wr) begin
                    s_next.step = 3'd1;
                    s_next.op = OP_NONE;
                    s_next.st = (is_a && d8 == D_AA) ? S_SEQ : S_READ;
                end
            end
            S_SEQ: begin
                if (bus.rd) begin
                    s_next.refused = 1'b1;
                end
                if (bus.wr) begin
                    s_next.st = S_READ;
                    s_next.step = s_reg.step + 3'd1;
                    unique case (s_reg.step)
                        3'd1: if (is_b && d8 == D_55) s_next.st = S_SEQ;
                        3'd2: if (is_a) begin
                            if (d8 == D_PROG) begin
                                s_next.st = S_LOAD;
                                s_next.widx = '0;
                            end else if (d8 == D_ERASE) begin
                                s_next.st = S_SEQ;
                            end else if (d8 == D_IDREAD) begin
                                s_next.st = S_IDRD;
                            end
                        end
                        3'd3: if (is_a && d8 == D_AA) s_next.st = S_SEQ;
                        3'd4: if (is_b && d8 == D_55) s_next.st = S_SEQ;
                        3'd5: begin
                            if (is_a && d8 == D_CHIP) begin
                                s_next.op = OP_CHIP;
                                s_next.st = (&prot) ? S_READ : S_BUSY;
                            end else if (d8 == D_BLOCK) begin
                                s_next.op = OP_BLOCK;
                                s_next.blk = waddr[WORD_W-1 -: BLK_W];
                                s_next.st = S_BUSY;
                            end
                        end
                        default: s_next.st = S_READ;
                    endcase
                    if (s_next.st == S_BUSY) begin
                        s_next.rdy = 1'b0;
                        s_next.cnt = CNT_W'(OP_CYC);
                    end
                end
            end
            S_LOAD: begin
                if (bus.rd) begin
                    s_next.refused = 1'b1;
                end
                if (bus.wr) begin
                    pb_we = 1'b1;
                    if (s_reg.widx == '0) begin
                        s_next.pbase = {waddr[WORD_W-1:PAGE_W], {PAGE_W{1'b0}}};
                        s_next.blk = waddr[WORD_W-1 -: BLK_W];
                    end
                    s_next.widx = s_reg.widx + 1'b1;
                    if (&s_reg.widx) begin
                        s_next.op = OP_PROG;
                        s_next.st = S_BUSY;
                        s_next.rdy = 1'b0;
                        s_next.cnt = CNT_W'(OP_CYC);
                    end
                end
            end
            S_BUSY: begin
                // stores are dropped here; the count reaching 1 or op_fail ends the operation
                s_next.refused = bus.rd;
                if (op_fail) begin
                    s_next.st = S_FAIL;
                end else if (s_reg.cnt == 1) begin
                    s_next.st = S_READ;
                    s_next.rdy = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            S_FAIL: begin
                s_next.refused = bus.rd;
            end
            default: s_next.st = S_READ;
        endcase
        s_next.rmode = (s_next.st == S_READ);
    end

    // ------------------------------------------------------------
    // state and array
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: S_READ, op: OP_NONE, step: '0, widx: '0, pbase: '0,
                       blk: '0, cnt: '0, rdy: 1'b1, refused: 1'b0, rvalid: 1'b0,
                       rdata: '0, rmode: 1'b1};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // array contents carry no reset; they model cells
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (pb_we) begin
                pagebuf[s_reg.widx] <= bus.wdata;
            end
            if (s_reg.st == S_BUSY && s_reg.cnt == 1 && !op_fail) begin
                for (int i = 0; i < NWORDS; i++) begin
                    if (!prot[i / (NWORDS / NBLK)]) begin
                        if (s_reg.op == OP_CHIP || (s_reg.op == OP_BLOCK
                            && BLK_W'(i / (NWORDS / NBLK)) == s_reg.blk)) begin
                            mem[i] <= NO_WRITE;
                        end else if (s_reg.op == OP_PROG
                            && (WORD_W'(i) & ~WORD_W'(PAGE_WORDS - 1)) == s_reg.pbase) begin
                            mem[i] <= mem[i] & pagebuf[i % PAGE_WORDS];
                        end
                    end
                end
            end
        end
    end
endmodule : fcs_device

// File: src/fcs_host.sv
// flash command sequencer: cpu end issuing store sequences
`timescale 1ns/1ps
module fcs_host
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // user request
    input wire logic req,
    input wire logic [2:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    output logic req_ack,
    output logic done,
    // cpu link
    fcs_bus_if.host bus
);
    typedef enum logic [3:0] {
        H_IDLE = 4'h1, H_SEND = 4'h2, H_WAIT = 4'h4, H_HOLD = 4'h8
    } fcs_hstate_t;
    typedef struct packed {
        fcs_hstate_t st;
        logic [2:0] op;
        logic [2:0] idx;
        logic [PAGE_W-1:0] w;
        logic [ADDR_W-1:0] a;
        logic [CNT_W-1:0] cnt;
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic ack;
        logic done;
    } fcs_host_state_t;
    fcs_host_state_t h_reg, h_next;
    logic [ADDR_W-1:0] ca, cb;
    logic [2:0] ncyc;

    assign ca = ADDR_W'({CMD_ADDR_A, 9'h000});
    assign cb = ADDR_W'({CMD_ADDR_B, 9'h000});
    assign ncyc = (h_reg.op == 3'(OP_PROG)) ? 3'd3 : 3'd6;
    assign bus.wr = h_reg.wr;
    assign bus.rd = h_reg.rd;
    assign bus.addr = h_reg.addr;
    assign bus.wdata = h_reg.wdata;
    assign req_ack = h_reg.ack;
    assign done = h_reg.done;

    always_comb begin
        h_next = h_reg;
        h_next.wr = 1'b0;
        h_next.rd = 1'b0;
        h_next.ack = 1'b0;
        h_next.done = 1'b0;
        unique case (h_reg.st)
            H_IDLE: if (req && bus.ready_busy_flag) begin
                h_next.ack = 1'b1;
                h_next.op = req_op;
                h_next.a = req_addr;
                h_next.idx = '0;
                h_next.w = '0;
                h_next.st = H_SEND;
            end
            H_SEND: begin
                h_next.wr = 1'b1;
                h_next.idx = h_reg.idx + 3'd1;
                h_next.addr = (h_reg.idx == 3'd1 || h_reg.idx == 3'd4) ? cb : ca;
                unique case ((h_reg.idx < ncyc) ? h_reg.idx : 3'd7)
                    3'd0, 3'd3: h_next.wdata = 32'(D_AA);
                    3'd1, 3'd4: h_next.wdata = 32'(D_55);
                    3'd2: h_next.wdata = 32'(h_reg.op == 3'(OP_PROG) ? D_PROG : D_ERASE);
                    default: begin
                        if (h_reg.op == 3'(OP_PROG)) begin
                            h_next.addr = h_reg.a + ADDR_W'({h_reg.w, 2'b00});
                            h_next.wdata = (h_reg.w == '0) ? req_data : NO_WRITE;
                            h_next.w = h_reg.w + 1'b1;
                            h_next.idx = h_reg.idx;
                            if (&h_reg.w) h_next.st = H_WAIT;
                        end else if (h_reg.op == 3'(OP_BLOCK)) begin
                            h_next.addr = h_reg.a;
                            h_next.wdata = 32'(D_BLOCK);
                            h_next.st = H_WAIT;
                        end else begin
                            h_next.wdata = 32'(D_CHIP);
                            h_next.st = H_WAIT;
                        end
                    end
                endcase
                if (h_reg.idx < ncyc && h_reg.idx == 3'd5) h_next.idx = h_reg.idx;
            end
            H_WAIT: if (h_reg.cnt == CNT_W'(2)) begin
                h_next.cnt = '0;
                if (bus.ready_busy_flag) begin
                    h_next.st = H_HOLD;
                    h_next.cnt = CNT_W'(READ_WAIT_CYC);
                end
            end else begin
                h_next.cnt = h_reg.cnt + 1'b1;
            end
            H_HOLD: if (h_reg.cnt == CNT_W'(1)) begin
                // one read-back of the base word; the caller judges the data
                h_next.done = 1'b1;
                h_next.rd = 1'b1;
                h_next.addr = h_reg.a;
                h_next.st = H_IDLE;
            end else begin
                h_next.cnt = h_reg.cnt - 1'b1;
            end
            default: h_next.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            h_reg <= '{st: H_IDLE, op: '0, idx: '0, w: '0, a: '0, cnt: '0,
                       wr: 1'b0, rd: 1'b0, addr: '0, wdata: '0, ack: 1'b0, done: 1'b0};
        end else if (clk_en) begin
            h_reg <= h_next;
        end
    end
endmodule : fcs_host

// File: verification/fcs_props.sv
// concurrent checks on the link between the host and device ends
`timescale 1ns/1ps
module fcs_props
    import fcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    input wire logic wr,
    input wire logic rd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic ready_busy_flag,
    input wire logic rd_refused
);
    // ----------------
    // busy stretch counter
    // ----------------
    logic [CNT_W-1:0] low_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_reg <= '0;
        end else begin
            low_reg <= ready_busy_flag ? '0 : low_reg + 1'b1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ----------------
    // command walks
    // ----------------
    sequence s_a(logic [7:0] d);
        wr && addr[15:9] == CMD_ADDR_A && wdata[7:0] == d;
    endsequence
    sequence s_unlock;
        s_a(D_AA) ##1 wr && addr[15:9] == CMD_ADDR_B && wdata[7:0] == D_55;
    endsequence
    sequence s_erase;
        s_unlock ##[1:4] s_a(D_ERASE) ##[1:4] s_unlock;
    endsequence
    prog_walk_a: assert property (
        s_unlock ##1 s_a(D_PROG) ##1 wr [*8] ##1 wr [*8] |-> ##[1:2] !ready_busy_flag)
        else $error("page program did not start busy");
    chip_walk_a: assert property (
        s_erase ##[1:4] s_a(D_CHIP) |-> ##[1:3] !ready_busy_flag)
        else $error("chip erase did not start busy");
    block_walk_a: assert property (
        s_erase ##[1:4] (wr && wdata[7:0] == D_BLOCK) |-> ##[1:3] !ready_busy_flag)
        else $error("block erase did not start busy");
    busy_len_a: assert property (
        $rose(ready_busy_flag) |-> low_reg >= OP_CYC - 1 && low_reg <= OP_CYC + 1)
        else $error("busy stretch has wrong length");
    busy_hold_a: assert property ($fell(ready_busy_flag) |-> !ready_busy_flag [*8])
        else $error("busy flag released too early");
    read_refuse_a: assert property (rd && !ready_busy_flag |=> rd_refused && !rvalid)
        else $error("read served while busy");
    rvalid_cause_a: assert property (rvalid |-> $past(rd) && $past(ready_busy_flag))
        else $error("read data without a served read");
    refuse_cause_a: assert property (rd_refused |-> $past(rd))
        else $error("refusal without a read");
    host_ready_a: assert property (wr |-> ready_busy_flag)
        else $error("host stored while busy");
    host_single_a: assert property (wr |-> !rd)
        else $error("host mixed read and store");
endmodule : fcs_props

// File: verification/tb_top.sv
// self-checking bench: joined host and device, plus a directly driven device
`timescale 1ns/1ps
module tb_top;
    import fcs_pkg::*;
    localparam logic [ADDR_W-1:0] CA = ADDR_W'({CMD_ADDR_A, 9'h000});
    localparam logic [ADDR_W-1:0] CB = ADDR_W'({CMD_ADDR_B, 9'h000});
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_data = '0;
    logic req_ack;
    logic done;
    logic rm_a;
    logic rm_b;
    logic [NBLK-1:0] prot_b = 4'h0;
    logic op_fail_b = 1'b0;
    int mismatches = 0;
    int checks = 0;
    int n;
    fcs_bus_if bus_a ();
    fcs_bus_if bus_b ();
    always #10 clock = ~clock;
    fcs_host i_fcs_host (.clock(clock), .rst(rst), .clk_en(1'b1), .req(req), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .req_ack(req_ack), .done(done), .bus(bus_a));
    fcs_device i_fcs_device (.clock(clock), .rst(rst), .clk_en(1'b1), .bus(bus_a),
        .prot(4'h0), .op_fail(1'b0), .read_mode(rm_a));
    fcs_device i_fcs_device_b (.clock(clock), .rst(rst), .clk_en(1'b1), .bus(bus_b),
        .prot(prot_b), .op_fail(op_fail_b), .read_mode(rm_b));
    fcs_props i_fcs_props (.clock(clock), .rst(rst), .wr(bus_a.wr), .rd(bus_a.rd),
        .addr(bus_a.addr), .wdata(bus_a.wdata), .rdata(bus_a.rdata), .rvalid(bus_a.rvalid),
        .ready_busy_flag(bus_a.ready_busy_flag), .rd_refused(bus_a.rd_refused));
    // ----------------
    // access tasks
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // the strobe stays up between stores; each store drives it high again and a later task lowers it
    task automatic store(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_b.wr <= 1'b1;
        bus_b.addr <= a;
        bus_b.wdata <= {24'h0, d};
    endtask : store
    task automatic mode_is(input logic m);
        @(posedge clock);
        bus_b.wr <= 1'b0;
        #1;
        check(rm_b, m);
    endtask : mode_is
    task automatic hdr(input logic [7:0] d);
        store(CA, D_AA);
        store(CB, D_55);
        store(CA, d);
    endtask : hdr
    task automatic erase(input logic [7:0] d, input logic [ADDR_W-1:0] a);
        hdr(D_ERASE);
        store(CA, D_AA);
        store(CB, D_55);
        store(a, d);
        @(posedge clock);
        bus_b.wr <= 1'b0;
    endtask : erase
    task automatic prog_page(input int w, input logic [31:0] base);
        hdr(D_PROG);
        for (int i = 0; i < PAGE_WORDS; i++) begin
            @(posedge clock);
            bus_b.addr <= ADDR_W'((w + i) * 4);
            bus_b.wdata <= base + 32'(i);
        end
        @(posedge clock);
        bus_b.wr <= 1'b0;
    endtask : prog_page
    task automatic read(input int w, input logic [31:0] exp, input logic ok);
        @(posedge clock);
        bus_b.wr <= 1'b0;
        bus_b.rd <= 1'b1;
        bus_b.addr <= ADDR_W'(w * 4);
        @(posedge clock);
        bus_b.rd <= 1'b0;
        #1;
        check(ok ? bus_b.rvalid : bus_b.rd_refused, 1);
        check(ok ? bus_b.rdata : 32'(bus_b.rvalid), exp);
    endtask : read
    task automatic wait_op(input logic busy);
        #1;
        n = 0;
        while (bus_b.ready_busy_flag !== 1'b1 && n < OP_CYC + 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (busy) check(n >= OP_CYC - 6, 1);
        check(bus_b.ready_busy_flag, 1);
        check(rm_b, 1);
    endtask : wait_op
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // ----------------
    // tests
    // ----------------
    initial begin
        bus_b.wr = 1'b0;
        bus_b.rd = 1'b0;
        bus_b.addr = '0;
        bus_b.wdata = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        #1;
        check(rm_b, 1);
        check(bus_b.ready_busy_flag, 1);
        erase(D_CHIP, CA);
        wait_op(1);
        read(5, NO_WRITE, 1);
        prog_page(0, 32'h0f0f_0000);
        read(2, 32'h0, 0);
        store(CA, D_READ);
        wait_op(1);
        read(3, 32'h0f0f_0003, 1);
        read(15, 32'h0f0f_000f, 1);
        prot_b <= 4'h1;
        erase(D_BLOCK, '0);
        wait_op(0);
        read(3, 32'h0f0f_0003, 1);
        erase(D_CHIP, CA);
        wait_op(1);
        read(3, 32'h0f0f_0003, 1);
        prot_b <= 4'h2;
        prog_page(64, 32'h0);
        wait_op(0);
        read(64, NO_WRITE, 1);
        prot_b <= 4'hf;
        erase(D_CHIP, CA);
        #1;
        check(bus_b.ready_busy_flag, 1);
        store(CA, D_AA);
        store(CB, 8'h12);
        mode_is(1);
        store(CA, D_AA);
        store(CB, D_55);
        mode_is(0);
        store(CA, D_READ);
        mode_is(1);
        hdr(D_IDREAD);
        mode_is(0);
        read(3, 32'h0, 1);
        store(CA, D_READ);
        mode_is(1);
        for (int op = 1; op < 4; op++) begin
            @(posedge clock);
            req <= 1'b1;
            req_op <= 3'(op);
            req_addr <= ADDR_W'(128 * 4);
            req_data <= 32'h1234_5678;
            n = 0;
            do begin
                @(posedge clock);
                #1;
                n++;
            end while (req_ack !== 1'b1 && n < 50);
            check(req_ack, 1);
            @(posedge clock);
            req <= 1'b0;
            n = 0;
            while (done !== 1'b1 && n < READ_WAIT_CYC + 200) begin
                @(posedge clock);
                #1;
                n++;
            end
            check(done, 1);
            check(n > READ_WAIT_CYC, 1);
            check(rm_a, 1);
            @(posedge clock);
            #1;
            check(bus_a.rvalid, 1);
            if (op > 1) check(bus_a.rdata, NO_WRITE);
        end
        prot_b <= 4'h0;
        prog_page(128, 32'h0);
        op_fail_b <= 1'b1;
        repeat (OP_CYC + 8) @(posedge clock);
        #1;
        check(bus_b.ready_busy_flag, 0);
        read(3, 32'h0, 0);
        rst <= 1'b1;
        op_fail_b <= 1'b0;
        // one extra edge: reset rose off the edge and must still span the minimum
        repeat (RST_MIN_CYC + 1) @(posedge clock);
        rst <= 1'b0;
        #1;
        check(bus_b.ready_busy_flag, 1);
        check(rm_b, 1);
        summarize();
    end
    // three host operations each hold about ten thousand cycles
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        summarize();
    end
endmodule : tb_top
